/* File: rtl/mbs_regs.vh */
// constants for the modbus-rtu slave frame handler
`ifndef MBS_REGS_VH
`define MBS_REGS_VH
// crc16 arithmetic
`define MBS_CRC_INIT   16'hffff
`define MBS_CRC_POLY   16'ha001
`define MBS_CRC_BITS   8
// idle gap: 3.5 character times as 7/2
`define MBS_GAP_MUL    3'h7
`define MBS_GAP_SHR    1
// addresses
`define MBS_BCAST      8'h00
`define MBS_ADDR_MIN   8'h01
`define MBS_ADDR_MAX   8'hf7
// command codes
`define MBS_FC_READ    8'h03
`define MBS_FC_WRITE   8'h06
`define MBS_EXC_FLAG   8'h80
// error codes
`define MBS_ERR_CMD    8'h01
`define MBS_ERR_ADDR   8'h02
`define MBS_ERR_DATA   8'h03
`define MBS_ERR_PROC   8'h04
// frame layout (byte index)
`define MBS_B_STN      3'h0
`define MBS_B_CMD      3'h1
`define MBS_B_AH       3'h2
`define MBS_B_AL       3'h3
`define MBS_B_NH       3'h4
`define MBS_B_NL       3'h5
`define MBS_REQ_LEN    8'h08
`define MBS_MIN_LEN    8'h04
`define MBS_BUF_LAST   8'h07
`define MBS_RSP_HDR    5'h03
`define MBS_ERR_LEN    5'h05
`define MBS_WR_LEN     5'h08
`define MBS_CRC_LEN    5'h02
// word count limits
`define MBS_MAX_WORDS  16'h000c
`define MBS_GROUP_SIZE 9'h100
// special (non-parameter) location groups
`define MBS_SP_SET     8'h10
`define MBS_SP_INIT    8'h1f
`define MBS_SP_CTRL    8'h20
`define MBS_SP_STAT    8'h30
`define MBS_SP_FAULT   8'h80
`endif

/* File: rtl/mbs_crc_byte.v */
// one-byte crc16 update step, reflected form
`default_nettype none
module mbs_crc_byte (
    // running value
    input  wire [15:0] crc_in,
    // data byte, eight data bits only
    input  wire [7:0]  data,
    // updated value
    output reg  [15:0] crc_out
);
`include "mbs_regs.vh"
    integer i;
    // xor byte in, then shift right eight times
    always @* begin
        crc_out = crc_in ^ {8'h00, data};
        for (i = 0; i < `MBS_CRC_BITS; i = i + 1) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ `MBS_CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/mbs_slave.v */
// modbus-rtu slave frame handler: framing, decode, crc, reply
// Overview of operation
// - answer own station 1..247; broadcast 0 writes are carried out without reply
// - idle gap over 3.5 chars frames data
// - drive the line only while replying
// - only word read 0x03, write 0x06
// - read up to 12, within group
// - faults or failed access give error reply
// - codes 01 cmd 02 addr 03 data 04 proc
// - parameter address high byte first
// - read count high first; write has none
// - data words high byte first
// - check value low byte first
// - crc covers frame, mismatch is error
// - crc init ffff, poly a001, 8 shifts
// - only eight data bits enter crc
// - decode parameter and special locations
// - high byte group, low byte index
`default_nettype none
module mbs_slave (
    // clock and reset
    input  wire        MCLK,
    input  wire        NRST,
    // configuration
    input  wire [7:0]  STATION_ADDR,
    input  wire [15:0] CHAR_CYCLES,
    // received bytes from the uart
    input  wire [7:0]  RX_DATA,
    input  wire        RX_VALID,
    // bytes to the uart
    output reg  [7:0]  TX_DATA,
    output wire        TX_VALID,
    input  wire        TX_READY,
    input  wire        TX_IDLE,
    output wire        LINE_DRIVE,
    // parameter store access
    output wire        PAR_REQ,
    output reg         PAR_WR,
    output reg  [15:0] PAR_ADDR,
    output reg  [15:0] PAR_WDATA,
    output reg         PAR_SPECIAL,
    input  wire        PAR_ACK,
    input  wire [15:0] PAR_RDATA,
    input  wire        PAR_FAIL
);
`include "mbs_regs.vh"
    // states
    localparam S_RECV  = 3'h0; // listening for a frame
    localparam S_REQ   = 3'h1; // issue store access
    localparam S_WAIT  = 3'h2; // wait store ack
    localparam S_LOAD  = 3'h3; // fetch next reply byte
    localparam S_SEND  = 3'h4; // offer byte to uart
    localparam S_DRAIN = 3'h5; // wait for last stop bit
    reg  [2:0]  state;         // controller state
    reg  [19:0] idle_cnt;      // cycles since last received byte
    reg  [7:0]  rx_len;        // bytes in current frame, saturating
    reg  [7:0]  rx_buf [0:7];  // first request bytes
    reg  [15:0] rx_crc;        // running crc over received bytes
    reg  [15:0] word_mem [0:11]; // words read for the reply
    reg  [3:0]  word_idx;      // word being accessed
    reg  [3:0]  word_num;      // words requested
    reg  [1:0]  kind;          // reply type
    reg  [7:0]  err_code;      // code for error reply
    reg  [4:0]  tx_idx;        // reply byte position
    reg  [4:0]  tx_len;        // reply length incl crc
    reg  [15:0] tx_crc;        // running crc over sent bytes
    reg  [7:0]  next_byte;     // reply byte at tx_idx
    wire [15:0] rx_crc_nx;     // crc after received byte
    wire [15:0] tx_crc_nx;     // crc after sent byte
    localparam K_READ = 2'h0, K_WRITE = 2'h1, K_ERR = 2'h2; // reply kinds
    // gap threshold, 3.5 characters
    wire [19:0] gap_cycles = (({4'h0, CHAR_CYCLES} * `MBS_GAP_MUL)
                             >> `MBS_GAP_SHR);
    wire gap_hit = idle_cnt >= gap_cycles;
    wire frame_end = (state == S_RECV) && (rx_len != 8'h00)
                     && gap_hit && !RX_VALID;
    // request field decode
    wire [7:0]  f_stn = rx_buf[`MBS_B_STN];
    wire [7:0]  f_cmd = rx_buf[`MBS_B_CMD];
    wire [15:0] f_addr = {rx_buf[`MBS_B_AH], rx_buf[`MBS_B_AL]};
    wire [15:0] f_val = {rx_buf[`MBS_B_NH], rx_buf[`MBS_B_NL]};
    wire stn_ok = (STATION_ADDR >= `MBS_ADDR_MIN)
                  && (STATION_ADDR <= `MBS_ADDR_MAX);
    wire is_bcast = f_stn == `MBS_BCAST;
    wire is_mine = stn_ok && (f_stn == STATION_ADDR);
    wire crc_ok = rx_crc == 16'h0000;
    wire cmd_rd = f_cmd == `MBS_FC_READ;
    wire cmd_wr = f_cmd == `MBS_FC_WRITE;
    wire len_ok = rx_len == `MBS_REQ_LEN;
    wire cnt_bad = cmd_rd && ((f_val == 16'h0000)
                   || (f_val > `MBS_MAX_WORDS));
    wire [8:0] grp_end = {1'b0, f_addr[7:0]} + {1'b0, f_val[7:0]};
    wire grp_bad = cmd_rd && !cnt_bad
                   && (grp_end > `MBS_GROUP_SIZE);
    // special locations live in fixed high-byte groups
    wire is_special = (f_addr[15:8] == `MBS_SP_SET)
                      || (f_addr[15:8] == `MBS_SP_INIT)
                      || (f_addr[15:8] == `MBS_SP_CTRL)
                      || (f_addr[15:8] == `MBS_SP_STAT)
                      || (f_addr[15:8] == `MBS_SP_FAULT);
    // fault code of a complete frame, zero when clean
    reg [7:0] chk_code;
    always @* begin
        if (!crc_ok) begin
            chk_code = `MBS_ERR_PROC;
        end else if (!(cmd_rd || cmd_wr)) begin
            chk_code = `MBS_ERR_CMD;
        end else if (!len_ok || cnt_bad) begin
            chk_code = `MBS_ERR_DATA;
        end else if (grp_bad) begin
            chk_code = `MBS_ERR_ADDR;
        end else begin
            chk_code = 8'h00;
        end
    end
    // crc engines, one per direction
    mbs_crc_byte u_rx_crc (
        .crc_in  (rx_crc),
        .data    (RX_DATA),
        .crc_out (rx_crc_nx)
    );
    mbs_crc_byte u_tx_crc (
        .crc_in  (tx_crc),
        .data    (TX_DATA),
        .crc_out (tx_crc_nx)
    );
    // reply byte selection
    wire [4:0] rd_off = tx_idx - `MBS_RSP_HDR;
    always @* begin
        next_byte = 8'h00;
        if (tx_idx == tx_len - `MBS_CRC_LEN) begin
            next_byte = tx_crc[7:0];
        end else if (tx_idx == tx_len - 5'h01) begin
            next_byte = tx_crc[15:8];
        end else if (kind == K_ERR) begin
            if (tx_idx == 5'h00) begin
                next_byte = f_stn;
            end else if (tx_idx == 5'h01) begin
                next_byte = f_cmd | `MBS_EXC_FLAG;
            end else begin
                next_byte = err_code;
            end
        end else if (kind == K_WRITE) begin
            next_byte = rx_buf[tx_idx[2:0]];
        end else if (tx_idx == 5'h00) begin
            next_byte = f_stn;
        end else if (tx_idx == 5'h01) begin
            next_byte = f_cmd;
        end else if (tx_idx == 5'h02) begin
            next_byte = {3'h0, word_num, 1'b0};
        end else if (!rd_off[0]) begin
            next_byte = word_mem[rd_off[4:1]][15:8];
        end else begin
            next_byte = word_mem[rd_off[4:1]][7:0];
        end
    end
    // handshakes
    assign PAR_REQ = state == S_REQ;
    assign TX_VALID = state == S_SEND;
    // line driven only for our own reply
    assign LINE_DRIVE = (state == S_LOAD) || (state == S_SEND)
                        || (state == S_DRAIN);
    // receive buffer; no reset needed, guarded by rx_len
    always @(posedge MCLK) begin
        if (state == S_RECV && RX_VALID && rx_len < `MBS_REQ_LEN
            && (rx_len != 8'h00 || gap_hit)) begin
            rx_buf[rx_len[2:0]] <= RX_DATA;
        end
    end
    // read words gathered from the store
    always @(posedge MCLK) begin
        if (state == S_WAIT && PAR_ACK && !PAR_WR) begin
            word_mem[word_idx] <= PAR_RDATA;
        end
    end
    // main controller
    always @(posedge MCLK) begin
        if (!NRST) begin
            state       <= S_RECV;
            idle_cnt    <= 20'h00000;
            rx_len      <= 8'h00;
            rx_crc      <= `MBS_CRC_INIT;
            word_idx    <= 4'h0;
            word_num    <= 4'h0;
            kind        <= K_READ;
            err_code    <= 8'h00;
            tx_idx      <= 5'h00;
            tx_len      <= 5'h00;
            tx_crc      <= `MBS_CRC_INIT;
            TX_DATA     <= 8'h00;
            PAR_WR      <= 1'b0;
            PAR_ADDR    <= 16'h0000;
            PAR_WDATA   <= 16'h0000;
            PAR_SPECIAL <= 1'b0;
        end else begin
            // idle timer restarts on any byte and while busy
            if (RX_VALID || state != S_RECV) begin
                idle_cnt <= 20'h00000;
            end else if (!gap_hit) begin
                idle_cnt <= idle_cnt + 20'h00001;
            end
            case (state)
            S_RECV: begin
                if (frame_end) begin
                    rx_len <= 8'h00;
                    rx_crc <= `MBS_CRC_INIT;
                    word_idx <= 4'h0;
                    word_num <= f_val[3:0];
                    PAR_ADDR <= f_addr;
                    PAR_WDATA <= f_val;
                    PAR_WR <= cmd_wr;
                    PAR_SPECIAL <= is_special;
                    err_code <= chk_code;
                    tx_idx <= 5'h00;
                    tx_crc <= `MBS_CRC_INIT;
                    // short frames are noise; never answer broadcast
                    if (rx_len < `MBS_MIN_LEN) begin
                        state <= S_RECV;
                    end else if (is_bcast) begin
                        if (chk_code == 8'h00 && cmd_wr) begin
                            state <= S_REQ;
                        end
                    end else if (is_mine) begin
                        if (chk_code != 8'h00) begin
                            kind <= K_ERR;
                            tx_len <= `MBS_ERR_LEN;
                            state <= S_LOAD;
                        end else begin
                            state <= S_REQ;
                        end
                    end
                end else if (RX_VALID && (rx_len != 8'h00 || gap_hit)) begin
                    // bytes before a gap are dropped until resync
                    rx_crc <= rx_crc_nx;
                    if (rx_len != 8'hff) begin
                        rx_len <= rx_len + 8'h01;
                    end
                end
            end
            S_REQ: begin
                state <= S_WAIT;
            end
            S_WAIT: begin
                if (PAR_ACK) begin
                    if (PAR_FAIL) begin
                        kind <= K_ERR;
                        err_code <= `MBS_ERR_PROC;
                        tx_len <= `MBS_ERR_LEN;
                        state <= is_bcast ? S_RECV : S_LOAD;
                    end else if (PAR_WR) begin
                        kind <= K_WRITE;
                        tx_len <= `MBS_WR_LEN;
                        state <= is_bcast ? S_RECV : S_LOAD;
                    end else if (word_idx + 4'h1 == word_num) begin
                        kind <= K_READ;
                        tx_len <= `MBS_RSP_HDR + `MBS_CRC_LEN
                                  + {word_num, 1'b0};
                        state <= S_LOAD;
                    end else begin
                        // consecutive parameters within the group
                        word_idx <= word_idx + 4'h1;
                        PAR_ADDR <= PAR_ADDR + 16'h0001;
                        state <= S_REQ;
                    end
                end
            end
            S_LOAD: begin
                TX_DATA <= next_byte;
                state <= S_SEND;
            end
            S_SEND: begin
                if (TX_READY) begin
                    // check bytes stay out of the sum, else the high byte
                    tx_crc <= (tx_idx < tx_len - `MBS_CRC_LEN) ? tx_crc_nx
                              : tx_crc;
                    tx_idx <= tx_idx + 5'h01;
                    if (tx_idx == tx_len - 5'h01) begin
                        state <= S_DRAIN;
                    end else begin
                        state <= S_LOAD;
                    end
                end
            end
            S_DRAIN: begin
                // release the line once the uart is quiet
                if (TX_IDLE) begin
                    state <= S_RECV;
                end
            end
            default: begin
                state <= S_RECV;
            end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: verif/mbs_slave_sva.sv */
// assertion checker for the modbus-rtu slave frame handler
`default_nettype none
module mbs_slave_sva (
    // clock and reset
    input wire logic        MCLK,
    input wire logic        NRST,
    // configuration and uart side
    input wire logic [7:0]  STATION_ADDR,
    input wire logic [7:0]  TX_DATA,
    input wire logic        TX_VALID,
    input wire logic        TX_READY,
    input wire logic        LINE_DRIVE,
    // store side
    input wire logic        PAR_REQ,
    input wire logic        PAR_WR,
    input wire logic [15:0] PAR_ADDR,
    input wire logic        PAR_SPECIAL,
    input wire logic        PAR_ACK
);
    timeunit 1ns;
    timeprecision 1ns;
    // one domain, so clock and reset are given once
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // the driver must be on whenever a byte is offered
    a_tx_in_drive: assert property (TX_VALID |-> LINE_DRIVE)
        else $error("byte offered with driver off");
    // a reply opens with the station address one cycle after enable
    a_drive_first_stn: assert property ($rose(LINE_DRIVE) |=>
        TX_VALID && TX_DATA == STATION_ADDR) else $error("bad first byte");
    // an offered byte waits unchanged for the uart
    a_tx_hold: assert property (TX_VALID && !TX_READY |=>
        TX_VALID && $stable(TX_DATA)) else $error("byte dropped early");
    // a load or drain cycle follows every accepted byte
    a_tx_space: assert property (TX_VALID && TX_READY |=> !TX_VALID)
        else $error("no load cycle");
    // store requests are single pulses
    a_req_pulse: assert property (PAR_REQ |=> !PAR_REQ)
        else $error("store request longer than one cycle");
    // store access only happens while the line is released
    a_req_quiet: assert property (PAR_REQ |-> !LINE_DRIVE)
        else $error("store access while replying");
    // address and direction hold past the request
    a_par_hold: assert property (PAR_REQ |=> $stable(PAR_ADDR) &&
        $stable(PAR_WR)) else $error("store address moved");
    // consecutive reads walk up by one word
    a_rd_addr_step: assert property (PAR_ACK && !PAR_WR ##1 PAR_REQ |->
        PAR_ADDR == $past(PAR_ADDR) + 16'h0001) else $error("read step");
    // special locations are flagged by their high byte
    a_special_map: assert property (PAR_REQ |-> PAR_SPECIAL ==
        (PAR_ADDR[15:8] inside {8'h10, 8'h1f, 8'h20, 8'h30, 8'h80}))
        else $error("special flag wrong");
    // main scenarios
    c_write: cover property (PAR_REQ && PAR_WR);
    c_reply: cover property ($rose(LINE_DRIVE));
    c_special: cover property (PAR_REQ && PAR_SPECIAL);
endmodule
bind mbs_slave mbs_slave_sva mbs_slave_sva_inst (.MCLK(MCLK), .NRST(NRST),
    .STATION_ADDR(STATION_ADDR), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .LINE_DRIVE(LINE_DRIVE), .PAR_REQ(PAR_REQ),
    .PAR_WR(PAR_WR), .PAR_ADDR(PAR_ADDR), .PAR_SPECIAL(PAR_SPECIAL),
    .PAR_ACK(PAR_ACK));
`default_nettype wire

/* File: verif/mbs_master_model.sv */
// bus master model: sends request frames, collects reply bytes
`default_nettype none
module mbs_master_model (
    // clock
    input  wire logic       MCLK,
    // request bytes toward the slave
    output var  logic [7:0] RX_DATA,
    output var  logic       RX_VALID,
    // reply bytes from the slave
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_VALID,
    output var  logic       TX_READY,
    output var  logic       TX_IDLE
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rsp[$];  // reply bytes seen
    logic       slow;    // uart only ready every other cycle
    int         busy;    // shifter cycles still to go
    initial begin
        RX_DATA = 8'h00;
        RX_VALID = 1'b0;
        TX_READY = 1'b0;
        TX_IDLE = 1'b1;
        slow = 1'b0;
        busy = 0;
    end
    // crc16 over the eight data bits of each byte
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction
    // full gap first, then one byte per character; cx spoils the crc
    task automatic send(input logic [7:0] b[$], input logic [15:0] cx);
        logic [15:0] c;
        c = crc16(b) ^ cx;
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        repeat (20) @(posedge MCLK);
        foreach (b[i]) begin
            #1 RX_DATA = b[i];
            RX_VALID = 1'b1;
            @(posedge MCLK);
            #1 RX_VALID = 1'b0;
            RX_DATA = ~b[i]; // released line must not look valid
            repeat (3) @(posedge MCLK);
        end
    endtask
    // uart side: take bytes, keep the shifter busy after each
    always @(posedge MCLK) begin
        if (TX_VALID && TX_READY) begin
            rsp.push_back(TX_DATA);
            busy <= 6;
        end else if (busy > 0) begin
            busy <= busy - 1;
        end
        TX_IDLE <= #1 (busy == 0) && !(TX_VALID && TX_READY);
        TX_READY <= #1 !slow || !TX_READY;
    end
endmodule
`default_nettype wire

/* File: verif/mbs_slave_tb_top.sv */
// self-checking bench for the modbus-rtu slave frame handler
`default_nettype none
module mbs_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        MCLK, NRST, RX_VALID, TX_READY, TX_IDLE, TX_VALID;
    logic        LINE_DRIVE, PAR_REQ, PAR_WR, PAR_SPECIAL, PAR_ACK;
    logic        PAR_FAIL;
    logic [7:0]  RX_DATA, TX_DATA, STATION_ADDR;
    logic [15:0] PAR_ADDR, PAR_WDATA, PAR_RDATA;
    logic [31:0] wr_seen;   // last store write, address and data
    logic [7:0]  none[$];   // empty reply
    int          error_cnt, cmp_count, cyc;
    mbs_slave mbs_slave_inst (.MCLK(MCLK), .NRST(NRST),
        .STATION_ADDR(STATION_ADDR), .CHAR_CYCLES(16'h0004), .RX_DATA(RX_DATA),
        .RX_VALID(RX_VALID), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
        .TX_READY(TX_READY), .TX_IDLE(TX_IDLE), .LINE_DRIVE(LINE_DRIVE),
        .PAR_REQ(PAR_REQ), .PAR_WR(PAR_WR), .PAR_ADDR(PAR_ADDR),
        .PAR_WDATA(PAR_WDATA), .PAR_SPECIAL(PAR_SPECIAL),
        .PAR_ACK(PAR_ACK), .PAR_RDATA(PAR_RDATA), .PAR_FAIL(PAR_FAIL));
    mbs_master_model m (.MCLK(MCLK), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
        .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
        .TX_IDLE(TX_IDLE));
    // clock, 8 ns period
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end
    // store: answer next cycle, data is the inverted address
    always @(posedge MCLK) begin
        PAR_ACK <= #1 PAR_REQ;
        PAR_RDATA <= #1 ~PAR_ADDR;
        PAR_FAIL <= #1 (PAR_ADDR == 16'h0777);
        if (PAR_REQ && PAR_WR) wr_seen <= {PAR_ADDR, PAR_WDATA};
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // send a frame, then compare the whole reply with crc appended
    task automatic run(input logic [7:0] q[$], e[$], input logic [15:0] cx);
        logic [15:0] c;
        int          n;
        m.rsp.delete();
        m.send(q, cx);
        c = m.crc16(e);
        if (e.size() > 0) begin
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        n = 0;
        while (m.rsp.size() < e.size() && n < 800) begin
            @(posedge MCLK);
            n++;
        end
        repeat (80) @(posedge MCLK);
        check("reply length", e.size(), m.rsp.size());
        foreach (e[i]) begin
            if (i < m.rsp.size()) begin
                check("reply byte", e[i], m.rsp[i]);
            end
        end
    endtask
    task automatic err(input logic [7:0] c, ah, al, nl, code,
                       input logic [15:0] cx);
        run('{8'h11, c, ah, al, 8'h00, nl},
            '{8'h11, c | 8'h80, code}, cx);
    endtask
    // twelve words ending on the last index of a group
    task automatic t_read_max();
        logic [7:0] e[$];
        e = '{8'h11, 8'h03, 8'h18};
        for (int a = 16'h01f4; a < 16'h0200; a++) begin
            e.push_back(~a[15:8]);
            e.push_back(~a[7:0]);
        end
        run('{8'h11, 8'h03, 8'h01, 8'hf4, 8'h00, 8'h0c}, e, 0);
    endtask
    // single write to a special location is echoed
    task automatic t_write();
        run('{8'h11, 8'h06, 8'h20, 8'h00, 8'h12, 8'h34},
            '{8'h11, 8'h06, 8'h20, 8'h00, 8'h12, 8'h34}, 0);
        check("store write", 32'h2000_1234, wr_seen);
    endtask
    // every error code
    task automatic t_errors();
        err(8'h04, 8'h01, 8'h05, 8'h01, 8'h01, 0);
        err(8'h10, 8'h01, 8'h05, 8'h01, 8'h01, 0);
        err(8'h03, 8'h01, 8'h05, 8'h0d, 8'h03, 0);
        err(8'h03, 8'h01, 8'h05, 8'h00, 8'h03, 0);
        err(8'h03, 8'h01, 8'hfe, 8'h03, 8'h02, 0);
        err(8'h03, 8'h01, 8'h05, 8'h01, 8'h04, 16'h0100);
        err(8'h03, 8'h07, 8'h77, 8'h01, 8'h04, 0);
        // seven-byte frame with a good check value: wrong length
        run('{8'h11, 8'h03, 8'h01, 8'h05, 8'h00},
            '{8'h11, 8'h83, 8'h03}, 0);
    endtask
    // other stations and broadcast stay silent
    task automatic t_silent();
        run('{8'h12, 8'h03, 8'h01, 8'h05, 8'h00, 8'h01}, none, 0);
        run('{8'h00, 8'h06, 8'h03, 8'h00, 8'hab, 8'hcd}, none, 0);
        check("broadcast write", 32'h0300_abcd, wr_seen);
        run('{8'h00, 8'h03, 8'h01, 8'h05, 8'h00, 8'h01}, none, 0);
        // three-byte fragment between gaps is noise
        run('{8'h11}, none, 0);
        // station number out of range answers nothing of its own
        #1 STATION_ADDR = 8'hf8;
        run('{8'hf8, 8'h03, 8'h01, 8'h05, 8'h00, 8'h01}, none, 0);
        #1 STATION_ADDR = 8'h11;
    endtask
    // stalling uart, word and crc byte order
    task automatic t_slow();
        m.slow = 1'b1;
        run('{8'h11, 8'h03, 8'h30, 8'h00, 8'h00, 8'h01},
            '{8'h11, 8'h03, 8'h02, 8'hcf, 8'hff}, 0);
        m.slow = 1'b0;
    endtask
    task stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // reset for 20 cycles, then the scenarios
    initial begin
        NRST = 1'b0;
        PAR_ACK = 1'b0;
        PAR_RDATA = 16'h0000;
        PAR_FAIL = 1'b0;
        wr_seen = 32'h0;
        STATION_ADDR = 8'h11;
        error_cnt = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (20) @(posedge MCLK);
        #1 NRST = 1'b1;
        t_read_max();
        t_write();
        t_errors();
        t_silent();
        t_slow();
        stop_test();
    end
endmodule
`default_nettype wire
